// ---- hdl/orac_pkg.sv ----
/*
  Package for the display addressing and command unit: command codes,
  field positions, reset values and shared carrier structs.
  Assumes a single core clock domain and synchronous host pin inputs.
*/
package orac_pkg;

  localparam int COL_W      = 8;
  localparam int LINE_W     = 6;
  localparam int NUM_COLS   = 132;
  localparam int NUM_LINES  = 64;

  localparam logic [7:0] COL_LAST      = 8'h83;
  localparam logic [7:0] COL_RESET     = 8'h00;
  localparam logic [5:0] LINE_RESET    = 6'h00;
  localparam logic [7:0] CONTRAST_RST  = 8'h80;

  // Command code groups, matched on the high bits; contrast and DC-DC mode match the whole byte
  localparam logic [3:0] CMD_COL_LO    = 4'h0;
  localparam logic [3:0] CMD_COL_HI    = 4'h1;
  localparam logic [1:0] CMD_START_LN  = 2'h1;
  localparam logic [6:0] CMD_SEG_REMAP = 7'h50;
  localparam logic [6:0] CMD_COM_SCAN  = 7'h64;
  localparam logic [6:0] CMD_DISP_ONOF = 7'h57;
  localparam logic [7:0] CMD_CONTRAST  = 8'h81;
  localparam logic [7:0] CMD_DCDC_MODE = 8'had;
  localparam logic [6:0] CMD_DCDC_SET  = 7'h45;

  // Host interface selection
  typedef enum logic [1:0]
  {
    ORAC_IF_6800,
    ORAC_IF_8080,
    ORAC_IF_SERIAL
  } orac_if_mode_t;

  // Parallel host pins, all synchronous to core_clk
  typedef struct packed
  {
    logic       cs_n;
    logic       command_data_select;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic [7:0] data_in;
  } orac_par_pins_t;

  // Serial host pins
  typedef struct packed
  {
    logic cs_n;
    logic command_data_select;
    logic sclk;
    logic sdata;
  } orac_ser_pins_t;

  // One classified host access
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic       is_data;
    logic [7:0] byte_val;
  } orac_access_t;

endpackage

// ---- hdl/orac_serial_rx.sv ----
/*
  Serial byte assembler: shifts bits msb first on each rising serial
  clock and presents a byte with its command/data flag.
  Assumes serial pins arrive synchronous to core_clk.
*/
`timescale 1ns/1ps
module orac_serial_rx
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire orac_pkg::orac_ser_pins_t pins,
  output logic                         byte_valid,
  output logic                         byte_is_data,
  output logic [7:0]                   byte_val
);
  import orac_pkg::*;

  logic [7:0] shift;
  logic [2:0] count;
  logic       sclk_prev;
  logic       rise;

  assign rise = pins.sclk & ~sclk_prev;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= pins.sclk;
  end

  // Deselect also empties the shift register and bit count
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift <= 8'h00; // [RULE_10]
      count <= 3'h0;
    end
    else if (pins.cs_n)
    begin
      shift <= 8'h00;
      count <= 3'h0;
    end
    else if (rise)
    begin
      shift <= {shift[6:0], pins.sdata}; // [RULE_17]
      count <= count + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      byte_valid   <= 1'b0;
      byte_is_data <= 1'b0;
      byte_val     <= 8'h00;
    end
    else
    begin
      byte_valid <= !pins.cs_n && rise && (count == 3'h7);
      if (!pins.cs_n && rise && (count == 3'h7))
      begin
        byte_is_data <= pins.command_data_select;
        byte_val     <= {shift[6:0], pins.sdata};
      end
    end
  end

endmodule

// ---- hdl/orac_cmd_unit.sv ----
/*
  Addressing and command unit of a 132x64 display controller: host
  access classification, command decode, column counter, segment and
  common mapping, start line, display clock select and reset defaults.
  Assumes host pins synchronous to core_clk and an external RAM that
  accepts one access per strobe on ram_we or ram_re.
*/
// Functional notes
// [RULE_01] Column counter steps after each RAM access
// [RULE_02] Host re-sends page and column across pages
// [RULE_03] Segment remap mirrors column order on outputs
// [RULE_04] Start line on first or last common
// [RULE_05] Sixty-four lines shown ascending from start
// [RULE_06] Start line change shifts mapping immediately
// [RULE_07] Clock select: oscillator or external timing input
// [RULE_08] Reset turns display off, drivers released
// [RULE_09] Reset: 132x64, unmirrored, normal common scan
// [RULE_10] Reset empties serial shift register
// [RULE_11] Reset start line is zero
// [RULE_12] Reset column counter is zero
// [RULE_13] Reset contrast 0x80, internal converter chosen
// [RULE_14] Commands complete in one core cycle
// [RULE_15] 8080 mode: low strobes for read, write
// [RULE_16] 6800 mode: rw level, high enable pulse
// [RULE_17] Serial bytes arrive msb first
// [RULE_18] Nibble commands load column low, high
// [RULE_19] Columns 0 to 131, page unchanged
// [RULE_20] Host sends only defined command codes
// [RULE_21] Data flag selects RAM or command
// [RULE_22] Host does one dummy read first
// [RULE_23] Start line command takes low six bits
// [RULE_24] Counter holds at last column
// [RULE_25] Column nibbles update independently
`timescale 1ns/1ps
module orac_cmd_unit
#(
  parameter int NUM_SEG = orac_pkg::NUM_COLS,
  parameter int NUM_COM = orac_pkg::NUM_LINES
)
(
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire orac_pkg::orac_if_mode_t  if_mode,
  input  wire orac_pkg::orac_par_pins_t par_pins,
  input  wire orac_pkg::orac_ser_pins_t ser_pins,
  input  wire logic                     osc_source_select,
  input  wire logic                     external_pixel_timing_in,
  input  wire logic                     osc_clk_in,
  input  wire logic [5:0]               scan_row,
  input  wire logic [7:0]               ram_rdata,
  output logic [7:0]                    data_out,
  output logic                          data_oe,
  output logic                          ram_we,
  output logic                          ram_re,
  output logic [7:0]                    ram_col,
  output logic [7:0]                    ram_wdata,
  output logic [5:0]                    ram_line,
  output logic [7:0]                    first_segment_output,
  output logic [7:0]                    last_segment_output,
  output logic [5:0]                    first_common_output,
  output logic [5:0]                    last_common_output,
  output logic                          drivers_oe,
  output logic                          display_on,
  output logic                          seg_reverse,
  output logic                          com_reverse,
  output logic [7:0]                    contrast,
  output logic                          dcdc_on,
  output logic                          osc_enable,
  output logic                          display_clk
);
  import orac_pkg::*;

  // ==========================================================
  // Functions
  // ==========================================================
  // Column shown on a segment position under the remap setting
  function automatic logic [7:0] seg_column(input logic [7:0] pos,
                                            input logic       rev);
    seg_column = rev ? COL_LAST - pos : pos; // [RULE_03]
  endfunction

  // RAM line driven on a common position, start line relative
  function automatic logic [5:0] com_line(input logic [5:0] pos,
                                          input logic [5:0] start,
                                          input logic       rev);
    logic [5:0] p;
    p = rev ? ~pos : pos; // [RULE_04]
    com_line = start + p; // [RULE_05]
  endfunction

  // ==========================================================
  // Host access classification
  // ==========================================================
  logic         rd_prev;
  logic         wr_prev;
  logic         ser_valid;
  logic         ser_is_data;
  logic [7:0]   ser_byte;
  orac_access_t acc;
  logic         contrast_pending;
  logic         dcdc_pending;
  logic [7:0]   col;
  logic [5:0]   start_line;

  orac_serial_rx u_serial_rx
  (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .pins         (ser_pins),
    .byte_valid   (ser_valid),
    .byte_is_data (ser_is_data),
    .byte_val     (ser_byte)
  );

  // Strobe history, held high when idle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
    end
    else
    begin
      rd_prev <= par_pins.read_strobe_n;
      wr_prev <= par_pins.write_strobe_n;
    end
  end

  // Access acts on the strobe's trailing edge, when data is settled
  always_comb
  begin
    acc          = '0;
    acc.byte_val = par_pins.data_in;
    acc.is_data  = par_pins.command_data_select; // [RULE_21]
    case (if_mode)
      ORAC_IF_8080:
      begin
        acc.rd = !par_pins.cs_n && par_pins.read_strobe_n
                 && !rd_prev; // [RULE_15]
        acc.wr = !par_pins.cs_n && par_pins.write_strobe_n
                 && !wr_prev; // [RULE_15]
      end
      ORAC_IF_6800:
      begin
        // read_strobe_n carries enable, write_strobe_n carries rw
        acc.rd = !par_pins.cs_n && !par_pins.read_strobe_n && rd_prev
                 && par_pins.write_strobe_n; // [RULE_16]
        acc.wr = !par_pins.cs_n && !par_pins.read_strobe_n && rd_prev
                 && !par_pins.write_strobe_n; // [RULE_16]
      end
      ORAC_IF_SERIAL:
      begin
        acc.wr       = ser_valid;
        acc.is_data  = ser_is_data;
        acc.byte_val = ser_byte;
      end
      default:
      begin
        acc.wr = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Command decode and control registers
  // ==========================================================
  logic cmd_wr;
  assign cmd_wr = acc.wr && !acc.is_data; // [RULE_14]

  // Second byte of the contrast command is taken whole; the DC-DC one must match on its high bits and sets dcdc_on from bit 0
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      contrast_pending <= 1'b0;
      dcdc_pending     <= 1'b0;
      contrast         <= CONTRAST_RST; // [RULE_13]
      dcdc_on          <= 1'b1; // [RULE_13]
    end
    else if (cmd_wr)
    begin
      if (contrast_pending)
      begin
        contrast         <= acc.byte_val;
        contrast_pending <= 1'b0;
      end
      else if (dcdc_pending)
      begin
        if (acc.byte_val[7:1] == CMD_DCDC_SET)
          dcdc_on <= acc.byte_val[0];
        dcdc_pending <= 1'b0;
      end
      else
      begin
        contrast_pending <= acc.byte_val == CMD_CONTRAST;
        dcdc_pending     <= acc.byte_val == CMD_DCDC_MODE;
      end
    end
  end

  logic single_cmd;
  assign single_cmd = cmd_wr && !contrast_pending && !dcdc_pending;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      start_line  <= LINE_RESET; // [RULE_11]
      seg_reverse <= 1'b0; // [RULE_09]
      com_reverse <= 1'b0; // [RULE_09]
      display_on  <= 1'b0; // [RULE_08]
    end
    else if (single_cmd)
    begin
      if (acc.byte_val[7:6] == CMD_START_LN)
        start_line <= acc.byte_val[5:0]; // [RULE_23]
      if (acc.byte_val[7:1] == CMD_SEG_REMAP)
        seg_reverse <= acc.byte_val[0];
      if (acc.byte_val[7:1] == CMD_COM_SCAN)
        com_reverse <= acc.byte_val[0];
      if (acc.byte_val[7:1] == CMD_DISP_ONOF)
        display_on <= acc.byte_val[0];
    end
  end

  // ==========================================================
  // Column address counter
  // ==========================================================
  // Saturation keeps stray accesses off column 0 of the same page
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      col <= COL_RESET; // [RULE_12]
    else if (single_cmd && acc.byte_val[7:4] == CMD_COL_LO)
      col <= {col[7:4], acc.byte_val[3:0]}; // [RULE_18] [RULE_25]
    else if (single_cmd && acc.byte_val[7:4] == CMD_COL_HI)
      col <= {acc.byte_val[3:0], col[3:0]}; // [RULE_18] [RULE_25]
    else if ((acc.rd || acc.wr) && acc.is_data)
    begin
      if (col < COL_LAST)
        col <= col + 8'h01; // [RULE_01] [RULE_19]
      else
        col <= COL_LAST; // [RULE_24]
    end
  end

  // ==========================================================
  // RAM port and read-back
  // ==========================================================
  // Read data lags one access, so the host's first read is a dummy
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ram_we    <= 1'b0;
      ram_re    <= 1'b0;
      ram_col   <= COL_RESET;
      ram_wdata <= 8'h00;
      data_out  <= 8'h00;
    end
    else
    begin
      ram_we <= acc.wr && acc.is_data; // [RULE_21]
      ram_re <= acc.rd && acc.is_data;
      if ((acc.rd || acc.wr) && acc.is_data)
        ram_col <= col;
      if (acc.wr)
        ram_wdata <= acc.byte_val;
      if (acc.rd && acc.is_data)
        data_out <= ram_rdata; // [RULE_22]
      else if (acc.rd)
        data_out <= {1'b0, display_on, 6'h00};
    end
  end

  // Parallel bus driven only during a read strobe
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      data_oe <= 1'b0;
    else
      data_oe <= (if_mode != ORAC_IF_SERIAL) && !par_pins.cs_n
                 && ((if_mode == ORAC_IF_8080)
                     ? !par_pins.read_strobe_n
                     : (par_pins.read_strobe_n
                        && par_pins.write_strobe_n));
  end

  // ==========================================================
  // Scan mapping
  // ==========================================================
  // Mapping is registered from start_line, so a new value reaches ram_line one core cycle later
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ram_line             <= LINE_RESET;
      first_segment_output <= COL_RESET;
      last_segment_output  <= COL_LAST;
      first_common_output  <= LINE_RESET;
      last_common_output   <= ~LINE_RESET;
      drivers_oe           <= 1'b0;
    end
    else
    begin
      ram_line <= com_line(scan_row, start_line, com_reverse); // [RULE_06]
      first_segment_output <= seg_column(COL_RESET, seg_reverse);
      last_segment_output  <= seg_column(COL_LAST, seg_reverse); // [RULE_03]
      first_common_output  <= com_line(LINE_RESET, start_line,
                                       com_reverse); // [RULE_04]
      last_common_output   <= com_line(~LINE_RESET, start_line,
                                       com_reverse); // [RULE_04]
      drivers_oe           <= display_on; // [RULE_08]
    end
  end

  // ==========================================================
  // Display clock source
  // ==========================================================
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      osc_enable  <= 1'b0;
      display_clk <= 1'b0;
    end
    else
    begin
      osc_enable  <= osc_source_select; // [RULE_07]
      display_clk <= osc_source_select ? osc_clk_in
                                       : external_pixel_timing_in; // [RULE_07]
    end
  end

endmodule

// ---- dv/orac_cmd_asserts.sv ----
/*
  Checker of the command unit outputs against their inputs.
  Assumes one core clock and an async active-low reset.
*/
`timescale 1ns/1ps
module orac_cmd_asserts
(
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire orac_pkg::orac_if_mode_t  if_mode,
  input wire orac_pkg::orac_par_pins_t par_pins,
  input wire logic [5:0] scan_row,
  input wire logic [5:0] ram_line,
  input wire logic       data_oe,
  input wire logic       osc_source_select,
  input wire logic       osc_clk_in,
  input wire logic       external_pixel_timing_in,
  input wire logic       ram_we,
  input wire logic       ram_re,
  input wire logic [7:0] ram_col,
  input wire logic [7:0] first_segment_output,
  input wire logic [7:0] last_segment_output,
  input wire logic [5:0] first_common_output,
  input wire logic [5:0] last_common_output,
  input wire logic       seg_reverse,
  input wire logic       com_reverse,
  input wire logic [7:0] contrast,
  input wire logic       dcdc_on,
  input wire logic       display_on,
  input wire logic       drivers_oe,
  input wire logic       osc_enable,
  input wire logic       display_clk
);
  import orac_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ======================================
  // Clock source
  int_clk_a: assert property (
    $past(resetn) && $past(osc_source_select)
      |-> display_clk == $past(osc_clk_in))
    else $error("Clock not from oscillator");
  ext_clk_a: assert property (
    $past(resetn) && !$past(osc_source_select)
      |-> display_clk == $past(external_pixel_timing_in))
    else $error("Clock not from timing input");
  osc_run_a: assert property (
    $past(resetn) |-> osc_enable == $past(osc_source_select))
    else $error("Oscillator enable wrong");
  // ======================================
  // RAM strobes and column range
  we_pulse_a: assert property (ram_we |=> !ram_we)
    else $error("Write strobe too long");
  re_pulse_a: assert property (ram_re ##1 ram_re |-> 1'b0)
    else $error("Read strobe too long");
  col_range_a: assert property (
    ram_we || ram_re |-> ram_col <= COL_LAST)
    else $error("Column out of range");
  // ======================================
  // Mapping and reset defaults
  seg_map_a: assert property (
    $past(resetn) && $stable(seg_reverse)
      |-> first_segment_output == (seg_reverse ? COL_LAST : COL_RESET)
      && last_segment_output == (seg_reverse ? COL_RESET : COL_LAST))
    else $error("Segment mapping wrong");
  com_span_a: assert property (
    $past(resetn) && $stable(com_reverse)
      |-> (com_reverse ? first_common_output - last_common_output
          : last_common_output - first_common_output) == 6'h3f)
    else $error("Common span wrong");
  rst_dflt_a: assert property (
    $rose(resetn) |-> contrast == CONTRAST_RST && dcdc_on
      && !display_on && !drivers_oe)
    else $error("Reset defaults wrong");
  row_map_a: assert property (
    $past(resetn) && !com_reverse && $stable(com_reverse)
      |-> ram_line == 6'($past(scan_row) + first_common_output))
    else $error("Row mapping wrong");
  // ======================================
  // Parallel bus drive
  bus_drv_a: assert property (
    data_oe |-> !$past(par_pins.cs_n) && if_mode != ORAC_IF_SERIAL)
    else $error("Bus driven when not selected");
  e_drv_a: assert property (
    data_oe && if_mode == ORAC_IF_6800 |-> $past(par_pins.read_strobe_n))
    else $error("Bus driven outside enable");
endmodule

bind orac_cmd_unit orac_cmd_asserts u_chk (.*);

// ---- dv/orac_host_model.sv ----
/*
  Host model: parallel and serial access tasks on the pin structs.
  Assumes one core clock; pins change just after rising edges.
*/
`timescale 1ns/1ps
module orac_host_model
(
  input  wire logic                core_clk,
  output orac_pkg::orac_par_pins_t par_pins,
  output orac_pkg::orac_ser_pins_t ser_pins
);
  import orac_pkg::*;
  initial
  begin
    par_pins = '{1'b1, 1'b0, 1'b1, 1'b1, 8'h00};
    ser_pins = '{1'b1, 1'b0, 1'b0, 1'b0};
  end
  // ======================================
  // Parallel access, 6800 when m68 set
  task automatic p_acc(input logic m68, input logic rd,
                       input logic cd, input logic [7:0] b);
    @(posedge core_clk);
    par_pins.cs_n                <= 1'b0;
    par_pins.command_data_select <= cd;
    par_pins.data_in             <= b;
    par_pins.read_strobe_n       <= m68 | !rd;
    par_pins.write_strobe_n      <= rd;
    @(posedge core_clk);
    par_pins.read_strobe_n  <= !m68;
    par_pins.write_strobe_n <= m68 ? rd : 1'b1;
    @(posedge core_clk);
    par_pins.cs_n    <= 1'b1;
    // Released bus must not keep the old byte
    par_pins.data_in <= ~b;
    repeat (2) @(posedge core_clk);
  endtask
  // ======================================
  // Serial bits, msb first; n below 8 is a partial byte
  task automatic s_tx(input logic cd, input logic [7:0] b, input int n);
    @(posedge core_clk);
    ser_pins.cs_n                <= 1'b0;
    ser_pins.command_data_select <= cd;
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      ser_pins.sclk  <= 1'b0;
      ser_pins.sdata <= b[7-i];
      @(posedge core_clk);
      ser_pins.sclk <= 1'b1;
    end
    @(posedge core_clk);
    ser_pins.sclk <= 1'b0;
    repeat (2) @(posedge core_clk);
    ser_pins.cs_n  <= 1'b1;
    ser_pins.sdata <= ~ser_pins.sdata;
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// ---- dv/tb_top.sv ----
/*
  Testbench of the command unit: host model, RAM model, test sequence.
  Assumes the checker is bound to the unit elsewhere.
*/
`timescale 1ns/1ps
module tb_top;
  import orac_pkg::*;
  logic           core_clk, resetn, osc_source_select, osc_clk_in;
  logic           external_pixel_timing_in, data_oe, ram_we, ram_re;
  logic           drivers_oe, display_on, seg_reverse, com_reverse;
  logic           dcdc_on, osc_enable, display_clk;
  orac_if_mode_t  if_mode;
  orac_par_pins_t par_pins;
  orac_ser_pins_t ser_pins;
  logic [5:0]     scan_row, ram_line, first_common_output;
  logic [5:0]     last_common_output;
  logic [7:0]     ram_rdata, data_out, ram_col, ram_wdata, contrast;
  logic [7:0]     first_segment_output, last_segment_output;
  logic [7:0]     wr_col, wr_dat;
  int             num_errors = 0;
  int             n_tests = 0;

  orac_cmd_unit u_dut (.*);
  orac_host_model u_host (.core_clk(core_clk), .par_pins(par_pins),
                          .ser_pins(ser_pins));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ======================================
  // RAM model: one cycle read latency, write capture
  always @(posedge core_clk)
  begin
    osc_clk_in <= ~osc_clk_in;
    scan_row <= scan_row + 6'h01;
    external_pixel_timing_in <= scan_row[2];
    if (ram_re)
      ram_rdata <= ram_col ^ 8'ha5;
    if (ram_we)
    begin
      wr_col <= ram_col;
      wr_dat <= ram_wdata;
    end
  end
  // ======================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic m, input logic [7:0] b);
    u_host.p_acc(m, 1'b0, 1'b0, b);
  endtask
  task automatic wr(input logic m, input logic [7:0] b);
    u_host.p_acc(m, 1'b0, 1'b1, b);
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    num_errors++;
    end_sim();
  end
  // ======================================
  // Test sequence
  initial
  begin
    resetn = 1'b0;
    if_mode = ORAC_IF_8080;
    osc_source_select = 1'b1;
    osc_clk_in = 1'b0;
    external_pixel_timing_in = 1'b0;
    scan_row = 6'h00;
    ram_rdata = 8'h00;
    do_reset();
    chk(display_on, 1'b0);
    chk(drivers_oe, 1'b0);
    chk(last_segment_output, COL_LAST);
    chk(first_common_output, LINE_RESET);
    chk(contrast, CONTRAST_RST);
    chk(dcdc_on, 1'b1);
    $display("test reset done");
    wr(1'b0, 8'h11);
    chk(wr_col, COL_RESET);
    chk(wr_dat, 8'h11);
    cmd(1'b0, 8'h18);
    cmd(1'b0, 8'h02);
    wr(1'b0, 8'haa);
    chk(wr_col, 8'h82);
    wr(1'b0, 8'h55);
    chk(wr_col, 8'h83);
    wr(1'b0, 8'h33);
    chk(wr_col, 8'h83);
    cmd(1'b0, 8'h05);
    cmd(1'b0, 8'h13);
    wr(1'b0, 8'h44);
    chk(wr_col, 8'h35);
    cmd(1'b0, 8'h12);
    cmd(1'b0, 8'h00);
    u_host.p_acc(1'b0, 1'b1, 1'b1, 8'h00);
    u_host.p_acc(1'b0, 1'b1, 1'b1, 8'h00);
    chk(data_out, 8'h85);
    wr(1'b0, 8'h66);
    chk(wr_col, 8'h22);
    $display("test column done");
    @(posedge core_clk);
    if_mode <= ORAC_IF_6800;
    cmd(1'b1, 8'h7f);
    chk(first_common_output, 6'h3f);
    cmd(1'b1, 8'h5d);
    chk(first_common_output, 6'h1d);
    chk(last_common_output, 6'h1c);
    cmd(1'b1, 8'hc9);
    chk(last_common_output, 6'h1d);
    cmd(1'b1, 8'ha1);
    chk(first_segment_output, COL_LAST);
    cmd(1'b1, 8'haf);
    cmd(1'b1, 8'h81);
    cmd(1'b1, 8'h3c);
    chk(contrast, 8'h3c);
    cmd(1'b1, 8'had);
    cmd(1'b1, 8'h8a);
    chk(dcdc_on, 1'b0);
    u_host.p_acc(1'b1, 1'b1, 1'b0, 8'h00);
    chk(data_out, 8'h40);
    wr(1'b1, 8'h77);
    chk(wr_dat, 8'h77);
    $display("test command done");
    @(posedge core_clk);
    if_mode <= ORAC_IF_SERIAL;
    u_host.s_tx(1'b1, 8'hff, 3);
    u_host.s_tx(1'b1, 8'hc3, 8);
    chk(wr_dat, 8'hc3);
    u_host.s_tx(1'b1, 8'hff, 3);
    do_reset();
    chk(display_on, 1'b0);
    chk(seg_reverse, 1'b0);
    chk(com_reverse, 1'b0);
    u_host.s_tx(1'b1, 8'h96, 8);
    chk(wr_dat, 8'h96);
    chk(wr_col, COL_RESET);
    $display("test serial done");
    osc_source_select <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(osc_enable, 1'b0);
    osc_source_select <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(osc_enable, 1'b1);
    $display("test clock done");
    end_sim();
  end
endmodule
